// [cpx_exception_regs.sv]
// The strobed register port is this design's own decision.
`include "cpx_params.svh"

module cpx_exception_regs
   import cpx_pkg::*;
#(
   parameter logic [3:0]  TIMER_DIV  = `CPX_TIMER_DIV,
   parameter logic [31:0] VEC_NORMAL = `CPX_VEC_NORMAL,
   parameter logic [31:0] VEC_BOOT   = `CPX_VEC_BOOT
)
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   // register move port
   input  wire logic [4:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [31:0]      reg_rdata,
   // instruction fetch
   input  wire logic             ifetch_valid,
   input  wire logic [31:0]      ifetch_vaddr,
   input  wire logic             ifetch_addr_err,
   // data access
   input  wire logic             dacc_valid,
   input  wire logic             dacc_load,
   input  wire logic             dacc_store,
   input  wire logic             dacc_cacheop,
   input  wire logic [31:0]      dacc_vaddr,
   input  wire logic             dacc_addr_err,
   // faulting address report
   input  wire logic             fault_valid,
   input  wire cpx_fault_kind_t  fault_kind,
   input  wire logic [31:0]      fault_vaddr,
   // exception sequencing from the core
   input  wire logic             exc_enter,
   input  wire logic             exc_return,
   input  wire logic             soft_reset,
   // interrupt sources
   input  wire logic [5:0]       ext_int,
   input  wire logic [1:0]       sw_irq,
   // cache refill requests into set A
   input  wire logic             icache_refill_a,
   input  wire logic             icache_set_a_valid,
   input  wire logic             dcache_refill_a,
   input  wire logic             dcache_set_a_valid,
   input  wire logic             dcache_store_hit,
   // results
   output logic                  instr_watch_point_take,
   output logic                  data_watch_point_take,
   output logic      [1:0]       watch_pending,
   output logic      [7:0]       irq_pending,
   output logic                  irq_enabled,
   output logic                  irq_take,
   output logic                  user_mode,
   output logic                  kernel_mode,
   output logic      [3:0]       cop_usable,
   output logic                  icache_refill_a_ok,
   output logic                  dcache_refill_a_ok,
   output logic                  dcache_store_update_ok,
   output logic      [31:0]      vector_base
);

   cpx_state_t  s;
   cpx_state_t  next_s;

   logic        exception_level;
   logic        error_level;
   logic        level_busy;
   logic        timer_tick;
   logic [31:0] timer_inc;
   logic        iw_hit;
   logic        dw_hit;
   logic        dw_load_hit;
   logic        dw_store_hit;
   logic [7:0]  irq_mask;

   assign exception_level        = s.processor_status[`CPX_ST_EXL];
   assign error_level        = s.processor_status[`CPX_ST_ERL];
   assign level_busy = exception_level | error_level;

   // ------------------------------------------------------------------
   // watch comparisons
   // ------------------------------------------------------------------
   assign iw_hit = ifetch_valid
                 & s.instr_watch_point[`CPX_IW_EN]
                 & (ifetch_vaddr[31:`CPX_IW_ADDR_LO]
                    == s.instr_watch_point[31:`CPX_IW_ADDR_LO]);

   assign dw_load_hit  = dacc_load & s.data_watch_point[`CPX_DW_LOAD_EN];
   assign dw_store_hit = dacc_store & s.data_watch_point[`CPX_DW_STORE_EN];

   // cache ops never compare, even on a matching address
   assign dw_hit = dacc_valid
                 & ~dacc_cacheop
                 & (dw_load_hit | dw_store_hit)
                 & (dacc_vaddr[31:`CPX_DW_ADDR_LO]
                    == s.data_watch_point[31:`CPX_DW_ADDR_LO]);

   cpx_watch u_instr_watch_point (
      .clk        (clk),
      .arst_n     (arst_n),
      .hit        (iw_hit),
      .higher_err (ifetch_addr_err),
      .level_busy (level_busy),
      .take       (instr_watch_point_take),
      .pending    (watch_pending[0])
   );

   cpx_watch u_data_watch_point (
      .clk        (clk),
      .arst_n     (arst_n),
      .hit        (dw_hit),
      .higher_err (dacc_addr_err),
      .level_busy (level_busy),
      .take       (data_watch_point_take),
      .pending    (watch_pending[1])
   );

   // ------------------------------------------------------------------
   // timer arithmetic
   // ------------------------------------------------------------------
   // free-running divider: no stall input exists, so pipeline state
   // cannot hold the timer back
   assign timer_tick = (s.div_cnt == TIMER_DIV - 4'h1);
   assign timer_inc  = s.cycle_timer + 32'h1;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;

      // read data stand only in the cycle after the strobe
      next_s.rdata = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            `CPX_REG_FVA:    next_s.rdata = s.fault_virtual_address;
            `CPX_REG_TIMER:  next_s.rdata = s.cycle_timer;
            `CPX_REG_CMP:    next_s.rdata = s.timer_compare;
            `CPX_REG_STATUS: next_s.rdata = s.processor_status;
            `CPX_REG_INSTR_WATCH_POINT: next_s.rdata = s.instr_watch_point;
            `CPX_REG_DATA_WATCH_POINT: next_s.rdata = s.data_watch_point;
            default:         next_s.rdata = 32'h0;
         endcase
      end

      // timer divider and count
      if (timer_tick) begin
         next_s.div_cnt     = 4'h0;
         next_s.cycle_timer = timer_inc;
      end else begin
         next_s.div_cnt     = s.div_cnt + 4'h1;
      end
      if (reg_wr && reg_addr == `CPX_REG_TIMER) begin
         next_s.cycle_timer = reg_wdata;
      end

      // compare write clears first, so a same-cycle match still lands
      if (reg_wr && reg_addr == `CPX_REG_CMP) begin
         next_s.timer_compare = reg_wdata;
         next_s.timer_pending = 1'b0;
      end
      if (timer_tick && timer_inc == s.timer_compare) begin
         next_s.timer_pending = 1'b1;
      end

      // watch registers, reserved bits forced to zero
      if (reg_wr && reg_addr == `CPX_REG_INSTR_WATCH_POINT) begin
         next_s.instr_watch_point = reg_wdata & `CPX_IW_WR_MASK;
      end
      if (reg_wr && reg_addr == `CPX_REG_DATA_WATCH_POINT) begin
         next_s.data_watch_point = reg_wdata & `CPX_DW_WR_MASK;
      end

      // status: software write, then core events on top
      if (reg_wr && reg_addr == `CPX_REG_STATUS) begin
         next_s.processor_status = reg_wdata & `CPX_ST_WR_MASK;
      end
      if (exc_return) begin
         if (error_level) begin
            next_s.processor_status[`CPX_ST_ERL] = 1'b0;
         end else begin
            next_s.processor_status[`CPX_ST_EXL] = 1'b0;
         end
      end
      if (exc_enter) begin
         next_s.processor_status[`CPX_ST_EXL] = 1'b1;
      end
      if (soft_reset) begin
         next_s.processor_status[`CPX_ST_ERL] = 1'b1;
         next_s.processor_status[`CPX_ST_BEV] = 1'b1;
         next_s.processor_status[`CPX_ST_SR]  = 1'b1;
      end

      // fault address: frozen under exception level, blind to bus errors
      if (fault_valid && !exception_level && fault_kind != CPX_FLT_BUS) begin
         next_s.fault_virtual_address = fault_vaddr;
      end

      // enable lag: set takes effect at most the lag count of cycles
      // after the write; clear drops ie_effective one cycle after the
      // status bit clears, so a disable lands one cycle late
      if (!s.processor_status[`CPX_ST_IE]) begin
         next_s.ie_lag_cnt   = 2'h0;
         next_s.ie_effective = 1'b0;
      end else begin
         if (s.ie_lag_cnt != `CPX_IE_LAG) begin
            next_s.ie_lag_cnt = s.ie_lag_cnt + 2'h1;
         end
         next_s.ie_effective = (s.ie_lag_cnt >= `CPX_IE_LAG - 2'h1);
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s                   <= '0;
         s.processor_status  <= `CPX_ST_RESET;
         s.instr_watch_point <= `CPX_WATCH_RESET;
         s.data_watch_point  <= `CPX_WATCH_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign reg_rdata = s.rdata;

   // timer shares line 7 with external line 5
   assign irq_pending = {ext_int[5] | s.timer_pending,
                         ext_int[4:0],
                         sw_irq};

   assign irq_mask = s.processor_status[`CPX_ST_IM_HI:`CPX_ST_IM_LO];

   assign irq_enabled = s.ie_effective & ~exception_level & ~error_level;
   assign irq_take    = irq_enabled & (|(irq_mask & irq_pending));

   assign user_mode   = ~s.processor_status[`CPX_ST_UM] & ~exception_level & ~error_level;
   assign kernel_mode = ~user_mode;

   assign cop_usable = {s.processor_status[`CPX_ST_CU_HI:`CPX_ST_CU_LO + 1],
                        s.processor_status[`CPX_ST_CU_LO] | kernel_mode};

   // lock only bites when set A holds a valid line
   assign icache_refill_a_ok = icache_refill_a
                             & ~(s.processor_status[`CPX_ST_IL]
                                 & icache_set_a_valid);
   assign dcache_refill_a_ok = dcache_refill_a
                             & ~(s.processor_status[`CPX_ST_DL]
                                 & dcache_set_a_valid);
   // store hits update regardless of the lock
   assign dcache_store_update_ok = dcache_store_hit;

   assign vector_base = s.processor_status[`CPX_ST_BEV] ? VEC_BOOT
                                                        : VEC_NORMAL;

endmodule // cpx_exception_regs

// [cpx_exception_regs_chk.sv]
module cpx_exception_regs_chk
#(
   parameter logic [31:0] VEC_NORMAL = 32'h00000000,
   parameter logic [31:0] VEC_BOOT   = 32'h00001000
)
(
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        ifetch_addr_err,
   input wire logic        dacc_valid,
   input wire logic        dacc_load,
   input wire logic        dacc_store,
   input wire logic        dacc_cacheop,
   input wire logic        dacc_addr_err,
   input wire logic        icache_refill_a,
   input wire logic        icache_set_a_valid,
   input wire logic        dcache_store_hit,
   input wire logic        instr_watch_point_take,
   input wire logic        data_watch_point_take,
   input wire logic [1:0]  watch_pending,
   input wire logic [7:0]  irq_pending,
   input wire logic        irq_enabled,
   input wire logic        irq_take,
   input wire logic        user_mode,
   input wire logic        kernel_mode,
   input wire logic [3:0]  cop_usable,
   input wire logic        icache_refill_a_ok,
   input wire logic        dcache_store_update_ok,
   input wire logic [31:0] vector_base
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_IRQ_TAKE: assert property (irq_take |-> irq_enabled && |irq_pending)
      else $error("interrupt taken while disabled or nothing pending");
   AST_VEC: assert property (vector_base == VEC_BOOT || vector_base == VEC_NORMAL)
      else $error("vector base is neither normal nor bootstrap");
   AST_COP0: assert property (kernel_mode |-> cop_usable[0])
      else $error("system coprocessor unusable in kernel mode");
   AST_MODE: assert property (user_mode != kernel_mode)
      else $error("user and kernel mode indications disagree");
   AST_CACHEOP: assert property (dacc_valid && dacc_cacheop && !watch_pending[1]
      |-> !data_watch_point_take) else $error("cache op raised data watch");
   AST_IW_ERR: assert property (ifetch_addr_err && !watch_pending[0] |-> !instr_watch_point_take)
      else $error("instruction watch beat an address error");
   AST_DW_ERR: assert property (dacc_addr_err && !watch_pending[1] |-> !data_watch_point_take)
      else $error("data watch beat an address error");
   AST_REFILL: assert property (icache_refill_a && !icache_set_a_valid |-> icache_refill_a_ok)
      else $error("refill into invalid set blocked");
   AST_STORE: assert property (dcache_store_update_ok == dcache_store_hit)
      else $error("store update inhibited");
   AST_PEND_CLR: assert property (watch_pending[0] && instr_watch_point_take |=> !watch_pending[0])
      else $error("pending watch not cleared after take");
   AST_PEND_HOLD: assert property (watch_pending[0] && !instr_watch_point_take |=> watch_pending[0])
      else $error("pending watch lost before take");
endmodule // cpx_exception_regs_chk

bind cpx_exception_regs cpx_exception_regs_chk #(.VEC_NORMAL(VEC_NORMAL), .VEC_BOOT(VEC_BOOT)) chk_i (
   .clk(clk), .arst_n(arst_n), .ifetch_addr_err(ifetch_addr_err), .dacc_valid(dacc_valid),
   .dacc_load(dacc_load), .dacc_store(dacc_store), .dacc_cacheop(dacc_cacheop),
   .dacc_addr_err(dacc_addr_err), .icache_refill_a(icache_refill_a),
   .icache_set_a_valid(icache_set_a_valid), .dcache_store_hit(dcache_store_hit),
   .instr_watch_point_take(instr_watch_point_take), .data_watch_point_take(data_watch_point_take), .watch_pending(watch_pending),
   .irq_pending(irq_pending), .irq_enabled(irq_enabled), .irq_take(irq_take),
   .user_mode(user_mode), .kernel_mode(kernel_mode), .cop_usable(cop_usable),
   .icache_refill_a_ok(icache_refill_a_ok), .dcache_store_update_ok(dcache_store_update_ok),
   .vector_base(vector_base));

// [cpx_exception_regs_tb.sv]
`include "cpx_params.svh"

module cpx_exception_regs_tb import cpx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] VN = 32'h00000100;
   localparam logic [31:0] VB = 32'h00002000;
   logic            clk = 1'b0;
   logic            arst_n = 1'b0;
   logic [4:0]      reg_addr = 5'h00;
   logic [31:0]     reg_wdata = 32'h0;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   logic [31:0]     reg_rdata;
   logic            ifetch_valid = 1'b0;
   logic            ifetch_addr_err = 1'b0;
   logic [31:0]     ifetch_vaddr = 32'h0;
   logic [3:0]      dac = 4'h0;
   logic            dacc_valid = 1'b0;
   logic [31:0]     dacc_vaddr = 32'h0;
   logic            fault_valid = 1'b0;
   cpx_fault_kind_t fault_kind = CPX_FLT_ADDR;
   logic [31:0]     fault_vaddr = 32'h0;
   logic [2:0]      evt = 3'h0;
   logic [4:0]      cch = 5'h00;
   logic [5:0]      ext_int = 6'h01;
   logic [1:0]      sw_irq = 2'b00;
   logic            instr_watch_point_take, data_watch_point_take, irq_enabled, irq_take, user_mode, kernel_mode;
   logic            iref_ok, dref_ok, store_ok;
   logic [1:0]      watch_pending;
   logic [7:0]      irq_pending;
   logic [3:0]      cop_usable;
   logic [31:0]     vector_base, d, a;
   int              fail_count = 0;
   int              cmp_count = 0;

   always #50 clk = ~clk;

   cpx_exception_regs #(.VEC_NORMAL(VN), .VEC_BOOT(VB)) dut (
      .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ifetch_valid(ifetch_valid),
      .ifetch_vaddr(ifetch_vaddr), .ifetch_addr_err(ifetch_addr_err),
      .dacc_valid(dacc_valid), .dacc_load(dac[3]), .dacc_store(dac[2]),
      .dacc_cacheop(dac[1]), .dacc_vaddr(dacc_vaddr), .dacc_addr_err(dac[0]),
      .fault_valid(fault_valid), .fault_kind(fault_kind), .fault_vaddr(fault_vaddr),
      .exc_enter(evt[0]), .exc_return(evt[1]), .soft_reset(evt[2]), .ext_int(ext_int),
      .sw_irq(sw_irq), .icache_refill_a(cch[4]), .icache_set_a_valid(cch[3]),
      .dcache_refill_a(cch[2]), .dcache_set_a_valid(cch[1]), .dcache_store_hit(cch[0]),
      .instr_watch_point_take(instr_watch_point_take), .data_watch_point_take(data_watch_point_take), .watch_pending(watch_pending),
      .irq_pending(irq_pending), .irq_enabled(irq_enabled), .irq_take(irq_take),
      .user_mode(user_mode), .kernel_mode(kernel_mode), .cop_usable(cop_usable),
      .icache_refill_a_ok(iref_ok), .dcache_refill_a_ok(dref_ok),
      .dcache_store_update_ok(store_ok), .vector_base(vector_base));

   task automatic conclude();
      $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] ad, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #50;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] ad, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #50;
      v = reg_rdata;
   endtask

   task automatic ev(input logic [2:0] e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= 3'h0;
      #50;
   endtask

   task automatic flt(input cpx_fault_kind_t k, input logic [31:0] v);
      @(posedge clk);
      fault_kind <= k;
      fault_vaddr <= v;
      fault_valid <= 1'b1;
      @(posedge clk);
      fault_valid <= 1'b0;
      #50;
   endtask

   // take outputs are combinational, so look mid-cycle
   task automatic fetch(input logic [31:0] v, input logic e, input logic x);
      @(posedge clk);
      ifetch_valid <= 1'b1;
      ifetch_vaddr <= v;
      ifetch_addr_err <= e;
      #50 chk(instr_watch_point_take, x);
      @(posedge clk);
      ifetch_valid <= 1'b0;
      ifetch_addr_err <= 1'b0;
      #50;
   endtask

   task automatic dacc(input logic [3:0] t, input logic [31:0] v, input logic x);
      @(posedge clk);
      dacc_valid <= 1'b1;
      dac <= t;
      dacc_vaddr <= v;
      #50 chk(data_watch_point_take, x);
      @(posedge clk);
      dacc_valid <= 1'b0;
      dac <= 4'h0;
      #50;
   endtask

   task automatic cache(input logic [4:0] c, input logic [2:0] x);
      @(posedge clk);
      cch <= c;
      #50 chk({iref_ok, dref_ok, store_ok}, x);
   endtask

   task automatic wt(input logic s);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #50;
         if ((s ? irq_take : irq_pending[7]) === 1'b1)
            return;
      end
      fail_count++;
      conclude();
   endtask

   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      #50 chk(vector_base, VB);
      chk(kernel_mode, 1'b1);
      rd(`CPX_REG_STATUS, d);
      chk(d, 32'h00400004);
      rd(`CPX_REG_DATA_WATCH_POINT, d);
      chk(d, 32'h0);
      wr(`CPX_REG_STATUS, 32'h0);
      chk(user_mode, 1'b1);
      chk(cop_usable[0], 1'b0);
      chk(vector_base, VN);
      wr(`CPX_REG_INSTR_WATCH_POINT, 32'h00001005);
      fetch(32'h00001007, 1'b0, 1'b1);
      fetch(32'h00001000, 1'b0, 1'b0);
      fetch(32'h00001004, 1'b1, 1'b0);
      wr(`CPX_REG_DATA_WATCH_POINT, 32'h0000200A);
      dacc(4'b1000, 32'h0000200C, 1'b1);
      dacc(4'b0100, 32'h0000200C, 1'b0);
      dacc(4'b1010, 32'h00002008, 1'b0);
      dacc(4'b1001, 32'h00002008, 1'b0);
      wr(`CPX_REG_DATA_WATCH_POINT, 32'h00002009);
      dacc(4'b0100, 32'h00002008, 1'b1);
      for (int k = 0; k < 4; k++) begin
         flt(cpx_fault_kind_t'(k), 32'h10000000 + k * 16);
         rd(`CPX_REG_FVA, d);
         chk(d, 32'h10000000 + k * 16);
      end
      flt(CPX_FLT_BUS, 32'h00005550);
      rd(`CPX_REG_FVA, d);
      chk(d, 32'h10000030);
      wr(`CPX_REG_FVA, 32'h0000FFFF);
      rd(`CPX_REG_FVA, d);
      chk(d, 32'h10000030);
      wr(`CPX_REG_STATUS, 32'h00000401);
      chk(irq_enabled, 1'b0);
      repeat (3) @(posedge clk);
      #50 chk(irq_enabled, 1'b1);
      wt(1'b1);
      ev(3'b001);
      chk(irq_enabled, 1'b0);
      chk(kernel_mode, 1'b1);
      flt(CPX_FLT_ADDR, 32'hAAAA0000);
      rd(`CPX_REG_FVA, d);
      chk(d, 32'h10000030);
      fetch(32'h00001004, 1'b0, 1'b0);
      chk(watch_pending[0], 1'b1);
      dacc(4'b0100, 32'h00002008, 1'b0);
      chk(watch_pending, 2'b11);
      ev(3'b010);
      chk(instr_watch_point_take, 1'b1);
      chk(data_watch_point_take, 1'b1);
      chk(user_mode, 1'b1);
      // divider phase is unknown, so judge the step across an even gap
      wr(`CPX_REG_TIMER, 32'hFFFFFFFE);
      rd(`CPX_REG_TIMER, a);
      repeat (20) @(posedge clk);
      rd(`CPX_REG_TIMER, d);
      chk({a[31:1], 1'b0}, 32'hFFFFFFFE);
      chk(d - a, 32'd11);
      chk({d[31:4], 4'h0}, 32'h0);
      wr(`CPX_REG_TIMER, 32'h0);
      wr(`CPX_REG_CMP, 32'h8);
      chk(irq_pending[7], 1'b0);
      wt(1'b0);
      wr(`CPX_REG_CMP, 32'h100);
      chk(irq_pending[7], 1'b0);
      rd(`CPX_REG_CMP, d);
      chk(d, 32'h100);
      @(posedge clk);
      ext_int <= 6'h00;
      sw_irq <= 2'b10;
      #50 chk(irq_take, 1'b0);
      wr(`CPX_REG_STATUS, 32'h00000201);
      chk(irq_pending, 32'h02);
      wt(1'b1);
      wr(`CPX_REG_STATUS, 32'hA1800000);
      chk(cop_usable, 32'hA);
      cache(5'b11111, 3'b001);
      cache(5'b10101, 3'b111);
      ev(3'b100);
      chk(vector_base, VB);
      rd(`CPX_REG_STATUS, d);
      chk(d, 32'hA1D00004);
      chk(cop_usable, 32'hB);
      conclude();
   end
endmodule // cpx_exception_regs_tb

// [cpx_params.svh]
`ifndef CPX_PARAMS_SVH
`define CPX_PARAMS_SVH

// register numbers on the move port
`define CPX_REG_FVA        5'h08
`define CPX_REG_TIMER      5'h09
`define CPX_REG_CMP        5'h0B
`define CPX_REG_STATUS     5'h0C
`define CPX_REG_INSTR_WATCH_POINT     5'h12
`define CPX_REG_DATA_WATCH_POINT     5'h13

// processor_status field positions
`define CPX_ST_IE          0
`define CPX_ST_EXL         1
`define CPX_ST_ERL         2
`define CPX_ST_UM          4
`define CPX_ST_UX          5
`define CPX_ST_IM_LO       8
`define CPX_ST_IM_HI       15
`define CPX_ST_DE          16
`define CPX_ST_CE          17
`define CPX_ST_CH          18
`define CPX_ST_SR          20
`define CPX_ST_BEV         22
`define CPX_ST_IL          23
`define CPX_ST_DL          24
`define CPX_ST_RE          25
`define CPX_ST_FR          26
`define CPX_ST_CU_LO       28
`define CPX_ST_CU_HI       31
`define CPX_ST_WR_MASK     32'hF7D7FF37
`define CPX_ST_RESET       32'h00400004

// watch register layouts
`define CPX_IW_EN          0
`define CPX_IW_ADDR_LO     2
`define CPX_IW_WR_MASK     32'hFFFFFFFD
`define CPX_DW_STORE_EN    0
`define CPX_DW_LOAD_EN     1
`define CPX_DW_ADDR_LO     3
`define CPX_DW_WR_MASK     32'hFFFFFFFB
`define CPX_WATCH_RESET    32'h00000000

// timing
`define CPX_TIMER_DIV      4'h2
`define CPX_IE_LAG         2'h3

// exception vector bases, plain defaults
`define CPX_VEC_NORMAL     32'h00000000
`define CPX_VEC_BOOT       32'h00001000

`endif

// [cpx_pkg.sv]
package cpx_pkg;

   typedef enum logic [2:0] {
      CPX_FLT_ADDR,
      CPX_FLT_BOUNDS,
      CPX_FLT_VC_DATA,
      CPX_FLT_VC_INSTR,
      CPX_FLT_BUS
   } cpx_fault_kind_t;

   typedef struct packed {
      logic pending;
   } cpx_watch_state_t;

   typedef struct packed {
      logic [31:0] fault_virtual_address;
      logic [31:0] cycle_timer;
      logic [31:0] timer_compare;
      logic [31:0] processor_status;
      logic [31:0] instr_watch_point;
      logic [31:0] data_watch_point;
      logic [31:0] rdata;
      logic        timer_pending;
      logic [3:0]  div_cnt;
      logic [1:0]  ie_lag_cnt;
      logic        ie_effective;
   } cpx_state_t;

endpackage

// [cpx_watch.sv]
module cpx_watch
   import cpx_pkg::*;
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic hit,
   input  wire logic higher_err,
   input  wire logic level_busy,
   output logic      take,
   output logic      pending
);

   cpx_watch_state_t s;
   cpx_watch_state_t next_s;
   logic             fresh;

   // a match on an access that also faults yields to the address error
   assign fresh = hit & ~higher_err;

   always_comb begin
      next_s = s;
      take   = 1'b0;
      if (level_busy) begin
         next_s.pending = s.pending | fresh;
      end else begin
         take           = fresh | s.pending;
         next_s.pending = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pending = s.pending;

endmodule // cpx_watch
